// ---- logic/compare_pkg.sv ----
// Package of constants and carrier types for the output compare channel
package compare_pkg;

   // ==========================================================
   // Register map
   localparam logic [3:0] ADDR_CONTROL   = 4'h0;
   localparam logic [3:0] ADDR_PRIMARY   = 4'h1;
   localparam logic [3:0] ADDR_SECONDARY = 4'h2;
   localparam logic [3:0] ADDR_STATUS    = 4'h3;
   localparam logic [3:0] ADDR_MASK      = 4'h4;

   // ==========================================================
   // Control field positions
   localparam int MODE_LSB       = 0;
   localparam int TIMESEL_BIT    = 3;
   localparam int FAULT_BIT      = 4;
   localparam int IDLE_STOP_BIT  = 13;
   localparam logic [15:0] CONTROL_WRITE_MASK = 16'h200F;
   localparam logic [15:0] CONTROL_RESET      = 16'h0000;
   localparam logic [15:0] COMPARE_RESET      = 16'h0000;
   localparam logic [2:0]  STATUS_RESET       = 3'h0;
   localparam int          CH_INDEX_DEFAULT   = 1;
   localparam int          CH_FAULT_A_LAST    = 4;

   // ==========================================================
   // Status bits: rising edge, falling edge, fault edge
   localparam int ST_RISE  = 0;
   localparam int ST_FALL  = 1;
   localparam int ST_FAULT = 2;

   typedef enum logic [2:0] {
      MODE_OFF    = 3'h0,
      MODE_LOW_OS = 3'h1,
      MODE_HI_OS  = 3'h2,
      MODE_TOGGLE = 3'h3,
      MODE_DLY_OS = 3'h4,
      MODE_CONT   = 3'h5,
      MODE_PWM    = 3'h6,
      MODE_PWM_F  = 3'h7
   } mode_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

endpackage : compare_pkg

// ---- logic/sync2.sv ----
// Two-stage synchroniser for pin inputs
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk_in,
   input  wire logic             rst_b_in,
   input  wire logic [WIDTH-1:0] async_in,
   input  wire logic [WIDTH-1:0] reset_val_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // Reset takes constant high so fault pins idle inactive
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_reg <= '1;
         sync_out <= '1;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

   logic unused_reset_val;
   assign unused_reset_val = ^reset_val_in;

endmodule : sync2

// ---- logic/output_compare_channel.sv ----
// Output compare channel: timer match, pin modes, fault, register slave
// ==========================================================
// Summary of operation
// - Timebase select bit 3 picks second shared timer when set, first otherwise.
// - Compare selected timer to one or two values; pin changes on match.
// - Mode bits 2:0; 000 disables channel, no interrupt, pin to port control.
// - Mode 001: start low, match forces high, interrupt on rising edge.
// - Mode 010: start high, match forces low, interrupt on falling edge.
// - Mode 011: keep level, each match toggles, interrupt on both edges.
// - Mode 100: start low, one pulse from matches, interrupt on its falling edge.
// - Mode 101: start low, repeating pulses, interrupt on each falling edge.
// - Mode 110: PWM, fault ignored, start 0 if primary zero else 1, no interrupt.
// - Mode 111: PWM with fault input, same start, interrupt on fault falling edge.
// - Fault input a serves channels one to four, input b five to eight.
// - Fault status bit 4 set on PWM fault, read-only, hardware clears it.
// - Idle-stop bit 13 set halts channel while processor idles.
// - Control bits 15:14 and 12:5 read back zero.
//
// Added by the designer: the register offsets and the strobed register port.
module output_compare_channel #(
   parameter int CH_INDEX = compare_pkg::CH_INDEX_DEFAULT,
   parameter int TW       = 16
) (
   input  wire logic          core_clk_in,
   input  wire logic          rst_b_in,
   input  wire logic [3:0]    addr_in,
   input  wire logic [15:0]   wdata_in,
   input  wire logic          wr_in,
   input  wire logic          rd_in,
   output logic      [15:0]   rdata_out,
   input  wire logic [TW-1:0] first_shared_timer_in,
   input  wire logic [TW-1:0] second_shared_timer_in,
   input  wire logic          cpu_idle_in,
   input  wire logic          fault_input_a_in,
   input  wire logic          fault_input_b_in,
   output logic               compare_output_pin_out,
   output logic               pin_owned_out,
   output logic               irq_out
);

   // ==========================================================
   // Register bus decode
   compare_pkg::bus_req_t bus;
   assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

   logic [15:0]   control_reg;
   logic [TW-1:0] primary_reg;
   logic [TW-1:0] secondary_reg;
   logic [2:0]    status_reg;
   logic [2:0]    mask_reg;
   logic          fault_flag_reg;

   wire wr_control = bus.wr && (bus.addr == compare_pkg::ADDR_CONTROL);
   wire wr_primary = bus.wr && (bus.addr == compare_pkg::ADDR_PRIMARY);
   wire wr_second  = bus.wr && (bus.addr == compare_pkg::ADDR_SECONDARY);
   wire wr_status  = bus.wr && (bus.addr == compare_pkg::ADDR_STATUS);
   wire wr_mask    = bus.wr && (bus.addr == compare_pkg::ADDR_MASK);

   compare_pkg::mode_t mode;
   assign mode = compare_pkg::mode_t'(control_reg[compare_pkg::MODE_LSB +: 3]);

   wire timesel   = control_reg[compare_pkg::TIMESEL_BIT];
   wire idle_stop = control_reg[compare_pkg::IDLE_STOP_BIT];

   // Unimplemented bits never stored, so they read zero
   wire [15:0] control_rd = (control_reg & compare_pkg::CONTROL_WRITE_MASK)
                          | ({15'h0000, fault_flag_reg} << compare_pkg::FAULT_BIT);

   logic [15:0] rdata_next;
   always_comb begin
      case (bus.addr)
         compare_pkg::ADDR_CONTROL:   rdata_next = control_rd;
         compare_pkg::ADDR_PRIMARY:   rdata_next = 16'(primary_reg);
         compare_pkg::ADDR_SECONDARY: rdata_next = 16'(secondary_reg);
         compare_pkg::ADDR_STATUS:    rdata_next = {13'h0000, status_reg};
         compare_pkg::ADDR_MASK:      rdata_next = {13'h0000, mask_reg};
         default:                     rdata_next = 16'h0000;
      endcase
   end

   // ==========================================================
   // Fault pin: synchronised before use
   logic [1:0] fault_sync;
   sync2 #(.WIDTH(2)) u_fault_sync (
      .core_clk_in  (core_clk_in),
      .rst_b_in     (rst_b_in),
      .async_in     ({fault_input_b_in, fault_input_a_in}),
      .reset_val_in (2'h3),
      .sync_out     (fault_sync)
   );

   // Channels above four listen to the second fault input
   wire fault_level = (CH_INDEX > compare_pkg::CH_FAULT_A_LAST) ? fault_sync[1]
                                                                : fault_sync[0];
   logic fault_prev_reg;
   wire  fault_fall = fault_prev_reg && !fault_level;

   // ==========================================================
   // Compare logic
   wire [TW-1:0] timer_sel = timesel ? second_shared_timer_in
                                     : first_shared_timer_in;
   wire run          = !(idle_stop && cpu_idle_in);
   wire match_pri    = run && (timer_sel == primary_reg);
   wire match_sec    = run && (timer_sel == secondary_reg);
   wire primary_zero = (primary_reg == '0);

   logic pin_reg;
   logic armed_reg;
   logic init_reg;
   logic pin_next;
   logic armed_next;

   // Mode entry is any control write, so rewriting the mode re-arms the channel
   always_comb begin
      pin_next   = pin_reg;
      armed_next = armed_reg;
      if (init_reg) begin
         armed_next = 1'b1;
         case (mode)
            compare_pkg::MODE_OFF:    pin_next = 1'b0;
            compare_pkg::MODE_LOW_OS: pin_next = 1'b0;
            compare_pkg::MODE_HI_OS:  pin_next = 1'b1;
            compare_pkg::MODE_TOGGLE: pin_next = pin_reg;
            compare_pkg::MODE_DLY_OS: pin_next = 1'b0;
            compare_pkg::MODE_CONT:   pin_next = 1'b0;
            compare_pkg::MODE_PWM:    pin_next = !primary_zero;
            compare_pkg::MODE_PWM_F:  pin_next = !primary_zero;
            default:                  pin_next = pin_reg;
         endcase
      end else begin
         case (mode)
            compare_pkg::MODE_LOW_OS: begin
               if (armed_reg && match_pri) begin
                  pin_next   = 1'b1;
                  armed_next = 1'b0;
               end
            end
            compare_pkg::MODE_HI_OS: begin
               if (armed_reg && match_pri) begin
                  pin_next   = 1'b0;
                  armed_next = 1'b0;
               end
            end
            compare_pkg::MODE_TOGGLE: begin
               if (match_pri) pin_next = !pin_reg;
            end
            compare_pkg::MODE_DLY_OS: begin
               if (armed_reg && match_pri && !pin_reg) begin
                  pin_next = 1'b1;
               end else if (pin_reg && match_sec) begin
                  pin_next   = 1'b0;
                  armed_next = 1'b0;
               end
            end
            compare_pkg::MODE_CONT: begin
               if (match_pri && !pin_reg) pin_next = 1'b1;
               else if (match_sec && pin_reg) pin_next = 1'b0;
            end
            compare_pkg::MODE_PWM, compare_pkg::MODE_PWM_F: begin
               // Period end at secondary value, duty end at primary
               if (fault_flag_reg) pin_next = 1'b0;
               else if (match_sec) pin_next = !primary_zero;
               else if (match_pri) pin_next = 1'b0;
            end
            default: pin_next = 1'b0;
         endcase
      end
   end

   wire pin_rise  = !pin_reg && pin_next;
   wire pin_fall  = pin_reg && !pin_next;
   wire active    = (mode != compare_pkg::MODE_OFF);
   wire fault_hit = (mode == compare_pkg::MODE_PWM_F) && fault_fall && !init_reg;

   // Interrupt events by mode
   wire ev_rise = pin_rise && !init_reg
                  && (mode == compare_pkg::MODE_LOW_OS || mode == compare_pkg::MODE_TOGGLE);
   wire ev_fall = pin_fall && !init_reg
                  && (mode == compare_pkg::MODE_HI_OS || mode == compare_pkg::MODE_TOGGLE
                      || mode == compare_pkg::MODE_DLY_OS || mode == compare_pkg::MODE_CONT);
   wire [2:0] events = {fault_hit, ev_fall, ev_rise};

   // Set wins over a same-cycle write-one clear
   wire [2:0] status_next = (status_reg & ~(wr_status ? bus.wdata[2:0] : 3'h0)) | events;

   // ==========================================================
   // Registers
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         control_reg    <= compare_pkg::CONTROL_RESET;
         primary_reg    <= TW'(compare_pkg::COMPARE_RESET);
         secondary_reg  <= TW'(compare_pkg::COMPARE_RESET);
         status_reg     <= compare_pkg::STATUS_RESET;
         mask_reg       <= compare_pkg::STATUS_RESET;
         fault_flag_reg <= 1'b0;
         fault_prev_reg <= 1'b1;
         pin_reg        <= 1'b0;
         armed_reg      <= 1'b0;
         init_reg       <= 1'b0;
         rdata_out      <= 16'h0000;
         irq_out        <= 1'b0;
         compare_output_pin_out <= 1'b0;
         pin_owned_out  <= 1'b0;
      end else begin
         if (wr_control) control_reg <= bus.wdata & compare_pkg::CONTROL_WRITE_MASK;
         if (wr_primary) primary_reg <= TW'(bus.wdata);
         if (wr_second)  secondary_reg <= TW'(bus.wdata);
         if (wr_mask)    mask_reg <= bus.wdata[2:0];
         status_reg     <= status_next;
         // Fault flag: hardware sets, hardware clears on mode rewrite
         if (fault_hit) fault_flag_reg <= 1'b1;
         else if (wr_control || mode != compare_pkg::MODE_PWM_F) fault_flag_reg <= 1'b0;
         fault_prev_reg <= fault_level;
         init_reg       <= wr_control;
         pin_reg        <= pin_next;
         armed_reg      <= armed_next;
         rdata_out      <= bus.rd ? rdata_next : 16'h0000;
         irq_out        <= |(status_next & mask_reg);
         compare_output_pin_out <= active ? pin_next : 1'b0;
         pin_owned_out  <= active;
      end
   end

   // ==========================================================
   // Assertions
   property p_timesel;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      match_pri |-> ((timesel ? second_shared_timer_in : first_shared_timer_in)
                     == primary_reg);
   endproperty
   a_timesel: assert property (p_timesel)
      else $error("match taken from the unselected timer");

   property p_off_quiet;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      !active |=> (!pin_owned_out && !compare_output_pin_out);
   endproperty
   a_off_quiet: assert property (p_off_quiet)
      else $error("disabled channel still owns or drives the pin");

   property p_low_os;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (mode == compare_pkg::MODE_LOW_OS && !init_reg && armed_reg && match_pri)
      |=> (pin_reg && status_reg[compare_pkg::ST_RISE]);
   endproperty
   a_low_os: assert property (p_low_os)
      else $error("low one-shot match did not raise pin and rise flag");

   property p_hi_os;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (mode == compare_pkg::MODE_HI_OS && !init_reg && armed_reg && match_pri)
      |=> (!pin_reg && status_reg[compare_pkg::ST_FALL]);
   endproperty
   a_hi_os: assert property (p_hi_os)
      else $error("high one-shot match did not drop pin and set fall flag");

   property p_toggle;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (mode == compare_pkg::MODE_TOGGLE && !init_reg && match_pri)
      |=> (pin_reg != $past(pin_reg));
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("toggle match left the pin unchanged");

   property p_dly_os;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (mode == compare_pkg::MODE_DLY_OS && !init_reg && pin_reg && match_sec)
      |=> (!pin_reg && status_reg[compare_pkg::ST_FALL]);
   endproperty
   a_dly_os: assert property (p_dly_os)
      else $error("delayed one-shot pulse did not end with fall flag");

   property p_cont;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (mode == compare_pkg::MODE_CONT && !init_reg && !pin_reg && match_pri)
      |=> pin_reg;
   endproperty
   a_cont: assert property (p_cont)
      else $error("continuous pulse did not start on primary match");

   property p_pwm_entry;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (init_reg && (mode == compare_pkg::MODE_PWM || mode == compare_pkg::MODE_PWM_F))
      |=> (pin_reg == $past(primary_reg != '0));
   endproperty
   a_pwm_entry: assert property (p_pwm_entry)
      else $error("pwm start level does not follow the primary value");

   property p_pwm_no_irq;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (mode == compare_pkg::MODE_PWM) |=> ((status_reg & ~$past(status_reg)) == 3'h0);
   endproperty
   a_pwm_no_irq: assert property (p_pwm_no_irq)
      else $error("plain pwm set a status bit");

   property p_fault_set;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      fault_hit |=> (fault_flag_reg && status_reg[compare_pkg::ST_FAULT]);
   endproperty
   a_fault_set: assert property (p_fault_set)
      else $error("fault edge did not set flag and status");

   property p_fault_hold;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (fault_flag_reg && !init_reg) |=> (!pin_reg && !compare_output_pin_out);
   endproperty
   a_fault_hold: assert property (p_fault_hold)
      else $error("pin active while a fault is held");

   property p_idle_halt;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (idle_stop && cpu_idle_in && !init_reg && !fault_flag_reg) |=> $stable(pin_reg);
   endproperty
   a_idle_halt: assert property (p_idle_halt)
      else $error("pin moved while halted in idle");

   property p_ctrl_zero;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      (bus.rd && bus.addr == compare_pkg::ADDR_CONTROL)
      |=> (rdata_out[15:14] == 2'h0 && rdata_out[12:5] == 8'h00);
   endproperty
   a_ctrl_zero: assert property (p_ctrl_zero)
      else $error("unimplemented control bits read nonzero");

   // Irq changes on the same edge as status since it is registered from the next value
   property p_irq_level;
      @(posedge core_clk_in) disable iff (!rst_b_in)
      irq_out == |(status_reg & $past(mask_reg));
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("irq does not follow masked status");

   // ==========================================================
   // Coverage of the main scenarios
   c_low_os_fire: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
      mode == compare_pkg::MODE_LOW_OS && armed_reg && match_pri);
   c_pwm_period: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
      mode == compare_pkg::MODE_PWM && match_sec);
   c_fault: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
      fault_hit);
   c_idle_halt: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
      idle_stop && cpu_idle_in && active);

endmodule : output_compare_channel

// ---- test/load_model.sv ----
// External load on the compare pin, a node with a pull-down
module load_model (
   input  wire logic pin_in,
   input  wire logic owned_in,
   output logic      level_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // Pull-down wins once the channel lets go of the node
   assign level_out = owned_in ? pin_in : 1'b0;
endmodule : load_model

// ---- test/tb.sv ----
// Self-checking bench for the output compare channel
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // Signals
   typedef struct packed {
      logic [3:0]  ctrl;
      logic [15:0] prim;
      logic [15:0] sec;
      logic        init;
      logic        p1;
      logic        i1;
      logic        p2;
      logic        i2;
   } row_t;
   localparam logic [15:0] PARK = 16'hFFF0;
   logic        core_clk_in = 1'b0;
   logic        rst_b_in    = 1'b0;
   logic [3:0]  addr        = 4'h0;
   logic [15:0] wdata       = 16'h0000;
   logic        wr          = 1'b0;
   logic        rd          = 1'b0;
   logic [15:0] t1          = PARK;
   logic [15:0] t2          = PARK;
   logic        idle        = 1'b0;
   logic        flt_a       = 1'b1;
   logic        flt_b       = 1'b1;
   logic [15:0] rdata;
   logic [15:0] rv;
   logic        pin;
   logic        owned;
   logic        irq;
   logic        level;
   int          failures    = 0;
   int          n_tests     = 0;
   // Mode 3 row relies on the level that the mode 2 row leaves behind
   row_t rows [7] = '{
      '{4'h1, 16'h0100, 16'h0200, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1},
      '{4'hA, 16'h0100, 16'h0200, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1},
      '{4'h3, 16'h0100, 16'h0200, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1},
      '{4'hC, 16'h0100, 16'h0200, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1},
      '{4'h5, 16'h0100, 16'h0200, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1},
      '{4'hE, 16'h0100, 16'h0200, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0},
      '{4'h7, 16'h0100, 16'h0200, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0}};
   always #12.5 core_clk_in = ~core_clk_in;
   output_compare_channel dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .first_shared_timer_in(t1), .second_shared_timer_in(t2), .cpu_idle_in(idle),
      .fault_input_a_in(flt_a), .fault_input_b_in(flt_b),
      .compare_output_pin_out(pin), .pin_owned_out(owned), .irq_out(irq));
   load_model load (.pin_in(pin), .owned_in(owned), .level_out(level));
   // ==========================================================
   // Tasks
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge core_clk_in);
      wr    <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [3:0] a);
      @(posedge core_clk_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge core_clk_in);
      rd   <= 1'b0;
      #1;
      rv = rdata;
   endtask : bus_rd
   // Unselected timer reaches the value first, so a wrong pick shows
   task automatic hit(input logic sel, input logic [15:0] v);
      @(posedge core_clk_in);
      t1 <= sel ? v : PARK;
      t2 <= sel ? PARK : v;
      @(posedge core_clk_in);
      t1 <= sel ? PARK : v;
      t2 <= sel ? v : PARK;
      @(posedge core_clk_in);
      t1 <= PARK;
      t2 <= PARK;
      repeat (3) @(posedge core_clk_in);
      #1;
   endtask : hit
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test
   // ==========================================================
   // Sequence
   initial begin
      repeat (20000) @(posedge core_clk_in);
      failures++;
      finish_test();
   end
   initial begin
      repeat (2) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      bus_rd(compare_pkg::ADDR_CONTROL);
      chk("control at reset", rv, compare_pkg::CONTROL_RESET);
      bus_wr(compare_pkg::ADDR_MASK, 16'h0007);
      hit(1'b0, 16'h0000);
      chk("irq when off", irq, 1'b0);
      chk("owned when off", owned, 1'b0);
      foreach (rows[i]) begin
         bus_wr(compare_pkg::ADDR_PRIMARY, rows[i].prim);
         bus_wr(compare_pkg::ADDR_SECONDARY, rows[i].sec);
         bus_wr(compare_pkg::ADDR_CONTROL, {12'h000, rows[i].ctrl});
         bus_wr(compare_pkg::ADDR_STATUS, 16'h0007);
         repeat (2) @(posedge core_clk_in);
         #1;
         chk("initial level", level, rows[i].init);
         hit(rows[i].ctrl[3], rows[i].prim);
         chk("level after primary", level, rows[i].p1);
         chk("irq after primary", irq, rows[i].i1);
         hit(rows[i].ctrl[3], rows[i].sec);
         chk("level after secondary", level, rows[i].p2);
         chk("irq after secondary", irq, rows[i].i2);
      end
      bus_wr(compare_pkg::ADDR_CONTROL, 16'hFFFF);
      bus_rd(compare_pkg::ADDR_CONTROL);
      chk("control readback", rv, 16'h200F);
      flt_b <= 1'b0;
      repeat (6) @(posedge core_clk_in);
      #1;
      chk("irq on other fault", irq, 1'b0);
      flt_a <= 1'b0;
      repeat (6) @(posedge core_clk_in);
      #1;
      chk("irq on fault", irq, 1'b1);
      chk("level on fault", level, 1'b0);
      bus_rd(compare_pkg::ADDR_CONTROL);
      chk("fault flag", rv, 16'h201F);
      hit(1'b0, 16'h0200);
      chk("level held after fault", level, 1'b0);
      flt_a <= 1'b1;
      flt_b <= 1'b1;
      bus_wr(compare_pkg::ADDR_CONTROL, 16'h0007);
      bus_rd(compare_pkg::ADDR_CONTROL);
      chk("fault flag cleared", rv, 16'h0007);
      bus_rd(compare_pkg::ADDR_STATUS);
      chk("status fault bit", rv, 16'h0004);
      bus_wr(compare_pkg::ADDR_MASK, 16'h0000);
      repeat (2) @(posedge core_clk_in);
      #1;
      chk("irq masked", irq, 1'b0);
      bus_wr(compare_pkg::ADDR_MASK, 16'h0004);
      repeat (2) @(posedge core_clk_in);
      #1;
      chk("irq unmasked", irq, 1'b1);
      bus_wr(compare_pkg::ADDR_STATUS, 16'h0004);
      repeat (2) @(posedge core_clk_in);
      #1;
      chk("irq cleared", irq, 1'b0);
      bus_wr(compare_pkg::ADDR_CONTROL, 16'h0006);
      flt_a <= 1'b0;
      repeat (6) @(posedge core_clk_in);
      #1;
      chk("irq fault ignored", irq, 1'b0);
      bus_rd(compare_pkg::ADDR_CONTROL);
      chk("no flag in plain pwm", rv, 16'h0006);
      flt_a <= 1'b1;
      // Idle halt is entered after the mode entry so the start level lands
      bus_wr(compare_pkg::ADDR_CONTROL, 16'h2001);
      repeat (2) @(posedge core_clk_in);
      idle <= 1'b1;
      hit(1'b0, 16'h0100);
      chk("halted in idle", level, 1'b0);
      bus_wr(compare_pkg::ADDR_CONTROL, 16'h0001);
      hit(1'b0, 16'h0100);
      chk("runs in idle", level, 1'b1);
      idle <= 1'b0;
      bus_wr(4'h5, 16'hFFFF);
      bus_rd(4'h5);
      chk("unmapped read", rv, 16'h0000);
      rst_b_in <= 1'b0;
      @(posedge core_clk_in);
      #1;
      chk("owned in reset", owned, 1'b0);
      chk("irq in reset", irq, 1'b0);
      finish_test();
   end
endmodule : tb
